// ==== verilog/radio_sleep_mode_controller.sv ====
// Purpose: sleep mode sequencer of a radio node with Wishbone registers
// Assumes: all inputs synchronous except sleep_request_in_i
// Notes:   one clock; no interrupt, no buffering
// How it works
// RL1: mode 0 never sleeps
// RL2: mode 1 request high: finish traffic, sleep
// RL3: pin sleep ends when request low
// RL4: mode 4 cycles; data extends wake
// RL5: awake indicator high awake, low asleep
// RL6: flow control: cts low awake, high asleep
// RL7: poll parent once per asynchronous wake
// RL8: mode 5 cycles only while request high
// RL9: mode 7 tracks network, never sleeps
// RL10: mode 8 sleeps, deaf while asleep
// RL11: own timing only until first sync
// RL12: queries report timing in use
// RL13: mode 8 indicator follows awake when enabled
// RL14: mode 8 cts deasserted while asleep
// RL15: unsynced: listen, sleep own period, repeat
// RL16: data restarts wake-time inactivity timer
// RL17: normal mode routes always, relays sync
// RL18: coordinator sends one sync per wake
// RL19: network adopts latest local timing
// RL20: non-coordinator never becomes coordinator
// RL21: timing change applies at next wake
// RL22: preferred coordinator syncs every wake
// RL23: request input through two flip-flops
//
// The register addresses and the Wishbone slave port were decided locally.
`include "sleep_ctrl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module radio_sleep_mode_controller #(
  parameter int unsigned TICK_CYCLES = `TICK_TIME_NS / `CLK_PERIOD_NS
)(
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // wishbone slave
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [7:0]              adr_i,
  input  wire logic [31:0]             dat_i,
  output logic      [31:0]             dat_o,
  output logic                         ack_o,
  // host pins
  input  wire logic                    sleep_request_in_i,
  output logic                         awake_o,
  output logic                         cts_n_o,
  // datapath activity
  input  wire logic                    serial_rx_i,
  input  wire logic                    rf_rx_i,
  input  wire logic                    busy_i,
  output logic                         rx_ready_o,
  output logic                         data_tx_ok_o,
  output logic                         poll_o,
  // peer nodes
  input  wire sleep_ctrl_pkg::sync_msg_t sync_rx_i,
  input  wire logic                    join_req_i,
  output sleep_ctrl_pkg::sync_msg_t    sync_tx_o
);
  // refuse a tick the prescaler cannot count
  if (TICK_CYCLES < 1) begin : g_chk
    $error("TICK_CYCLES must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register group
  logic [31:0]            ctrl, next_ctrl;          // mode and options
  sleep_ctrl_pkg::stime_t sleep_period, next_sleep; // local sleep period
  sleep_ctrl_pkg::stime_t wake_time, next_wake;     // local wake time
  logic                   local_chg, next_local_chg; // timing not yet applied
  logic                   ack, next_ack;            // bus answer
  logic [31:0]            rdat, next_rdat;          // read data
  logic [31:0]            cur_word;                 // addressed register
  logic [31:0]            wmerge;                   // word after byte lanes
  logic                   timing_wr;                // sleep or wake written
  logic                   apply;                    // local timing taken
  // sequencer signals read by the bus
  sleep_ctrl_pkg::stime_t cur_sleep, cur_wake;      // timing in use
  logic                   synced, coord;
  sleep_ctrl_pkg::seq_t   state;

  // control fields
  logic [3:0] mode;
  logic       flow_en, ind_en, poll_en, pref, noncoord;
  assign mode     = ctrl[`CTRL_MODE_LSB +: 4];
  assign flow_en  = ctrl[`CTRL_FLOW_BIT];
  assign ind_en   = ctrl[`CTRL_IND_BIT];
  assign poll_en  = ctrl[`CTRL_POLL_BIT];
  assign pref     = ctrl[`CTRL_PREF_BIT];
  assign noncoord = ctrl[`CTRL_NONCOORD_BIT];

  // byte-lane merge of a write into the old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  // register next values; ack one cycle after the request,
  // and a write lands on the edge where ack is sampled
  always_comb
  begin
    next_ctrl  = ctrl;
    next_sleep = sleep_period;
    next_wake  = wake_time;
    next_ack   = cyc_i & stb_i & ~ack;
    next_rdat  = rdat;
    timing_wr  = 1'b0;
    case (adr_i)
      `ADR_CTRL:         cur_word = ctrl;
      `ADR_SLEEP_PERIOD: cur_word = {16'h0000, sleep_period};
      `ADR_WAKE_TIME:    cur_word = {16'h0000, wake_time};
      `ADR_STATUS:       cur_word = {28'h0000000, coord, synced,
                           state == sleep_ctrl_pkg::S_NET_SLEEP,
                           state == sleep_ctrl_pkg::S_ASLEEP};
      `ADR_SYNCED_SLEEP: cur_word = {16'h0000, cur_sleep}; // see RL12
      `ADR_SYNCED_WAKE:  cur_word = {16'h0000, cur_wake};  // see RL12
      default:           cur_word = 32'h0000_0000;  // unmapped reads zero
    endcase
    wmerge = merge(cur_word, dat_i, sel_i);
    if (cyc_i & stb_i & ~ack)
      next_rdat = cur_word;
    if (cyc_i & stb_i & we_i & ack)
    begin
      case (adr_i)
        `ADR_CTRL:         next_ctrl = wmerge & `CTRL_MASK;
        `ADR_SLEEP_PERIOD:
        begin
          next_sleep = wmerge[15:0];
          timing_wr  = 1'b1;
        end
        `ADR_WAKE_TIME:
        begin
          next_wake = wmerge[15:0];
          timing_wr = 1'b1;
        end
        default:           next_ctrl = ctrl;  // read-only or unmapped
      endcase
    end
    // a new write wins over the apply in the same cycle
    next_local_chg = (local_chg & ~apply) | timing_wr; // see RL19
  end

  // register group flip-flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl         <= `CTRL_RST;
      sleep_period <= `SLEEP_PERIOD_RST;
      wake_time    <= `WAKE_TIME_RST;
      local_chg    <= 1'b0;
      ack          <= 1'b0;
      rdat         <= 32'h0000_0000;
    end
    else
    begin
      ctrl         <= next_ctrl;
      sleep_period <= next_sleep;
      wake_time    <= next_wake;
      local_chg    <= next_local_chg;
      ack          <= next_ack;
      rdat         <= next_rdat;
    end
  end
  assign ack_o = ack;
  assign dat_o = rdat;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer group
  sleep_ctrl_pkg::seq_t      next_state;
  sleep_ctrl_pkg::stime_t    timer, next_timer;     // ticks left in phase
  sleep_ctrl_pkg::stime_t    net_sleep, next_net_sleep;
  sleep_ctrl_pkg::stime_t    net_wake, next_net_wake;
  sleep_ctrl_pkg::sync_msg_t sync_tx, next_sync_tx;
  logic [31:0] presc, next_presc;                   // tick prescaler
  logic        next_synced;
  logic        req_s1, req_s2;                      // request synchroniser
  logic        poll, next_poll;
  logic        awake, next_awake;
  logic        cts_n, next_cts_n;
  logic        tick, tdone, data, req, wake_ev, wake_start, pin_hold;
  logic        sync_mode, async_mode, lp_next;

  // timing in use: own values until synced, network values after
  assign cur_sleep  = synced ? net_sleep : sleep_period; // see RL11 RL15
  assign cur_wake   = synced ? net_wake : wake_time;     // see RL11 RL15
  // a non-coordinator does not sync every wake; it sends its own sync only on a local timing change or a join
  assign coord      = pref & ~noncoord;                  // see RL20 RL22
  assign sync_mode  = (mode == `MODE_SUPPORT) | (mode == `MODE_SYNC);
  assign async_mode = (mode == `MODE_PIN) | (mode == `MODE_CYCLIC) |
                      (mode == `MODE_CYCLIC_PIN);

  // next state of the sleep sequencer
  always_comb
  begin
    next_state   = state;
    next_synced  = synced;
    next_net_sleep = net_sleep;
    next_net_wake  = net_wake;
    next_poll    = 1'b0;
    next_sync_tx = '0;
    wake_ev      = 1'b0;
    wake_start   = 1'b0;
    apply        = 1'b0;
    tick         = presc == TICK_CYCLES - 1;
    next_presc   = tick ? 32'h0000_0000 : presc + 32'h0000_0001;
    tdone        = timer == 16'h0000;
    next_timer   = (tick & ~tdone) ? timer - 16'h0001 : timer;
    req          = req_s2;                           // see RL23
    data         = (serial_rx_i | rf_rx_i) & (state != sleep_ctrl_pkg::S_ASLEEP);
    pin_hold     = (mode == `MODE_CYCLIC_PIN) & ~req;
    case (mode)
      `MODE_PIN:
        case (state)
          sleep_ctrl_pkg::S_AWAKE:
            if (req)
              next_state = sleep_ctrl_pkg::S_DRAIN;
          sleep_ctrl_pkg::S_DRAIN:
            if (!req)
              next_state = sleep_ctrl_pkg::S_AWAKE;
            else if (!busy_i)                        // see RL2
              next_state = sleep_ctrl_pkg::S_ASLEEP;
          sleep_ctrl_pkg::S_ASLEEP:
            if (!req)                                // see RL3
            begin
              next_state = sleep_ctrl_pkg::S_AWAKE;
              wake_ev    = 1'b1;
            end
          default: next_state = sleep_ctrl_pkg::S_AWAKE;
        endcase
      `MODE_CYCLIC, `MODE_CYCLIC_PIN:
        case (state)
          sleep_ctrl_pkg::S_AWAKE:
            if (data)
              next_timer = wake_time;                // see RL4 RL16
            else if (tdone & ~pin_hold)              // see RL8
              next_state = sleep_ctrl_pkg::S_DRAIN;
          sleep_ctrl_pkg::S_DRAIN:
            if (data | pin_hold)
            begin
              next_state = sleep_ctrl_pkg::S_AWAKE;
              next_timer = data ? wake_time : 16'h0000; // see RL16
            end
            else if (!busy_i)
            begin
              next_state = sleep_ctrl_pkg::S_ASLEEP;
              next_timer = sleep_period;
            end
          sleep_ctrl_pkg::S_ASLEEP:
            if (pin_hold | tdone)                    // see RL4 RL8
            begin
              next_state = sleep_ctrl_pkg::S_AWAKE;
              next_timer = 16'h0000;
              wake_ev    = 1'b1;
            end
          default: next_state = sleep_ctrl_pkg::S_AWAKE;
        endcase
      `MODE_SUPPORT, `MODE_SYNC:
        case (state)
          sleep_ctrl_pkg::S_AWAKE:
            if (tdone)
            begin
              // support nodes only mark the network asleep
              next_state = (mode == `MODE_SYNC) ? sleep_ctrl_pkg::S_DRAIN
                                                : sleep_ctrl_pkg::S_NET_SLEEP;
              next_timer = cur_sleep;                // see RL9 RL15
            end
          sleep_ctrl_pkg::S_DRAIN:
            if (!busy_i)
            begin
              next_state = sleep_ctrl_pkg::S_ASLEEP; // see RL10
              next_timer = cur_sleep;
            end
          default:
            if (tdone | (mode == `MODE_SUPPORT &&
                         state == sleep_ctrl_pkg::S_ASLEEP))
            begin
              next_state = sleep_ctrl_pkg::S_AWAKE;
              next_timer = cur_wake;
              wake_start = 1'b1;
            end
        endcase
      default: next_state = sleep_ctrl_pkg::S_AWAKE;   // see RL1
    endcase
    // start of a network wake: apply local timing, then send sync
    if (wake_start)
    begin
      if (local_chg)                                 // see RL21 RL19
      begin
        next_net_sleep = sleep_period;
        next_net_wake  = wake_time;
        next_timer     = wake_time;
        apply          = 1'b1;
      end
      if (coord | local_chg)                         // see RL18 RL22
      begin
        next_synced  = 1'b1;
        next_sync_tx = {1'b1, 1'b0,
                        local_chg ? sleep_period : cur_sleep,
                        local_chg ? wake_time : cur_wake};
      end
    end
    // a heard sync aligns the node and is rebroadcast once
    else if (sync_rx_i.valid & (state != sleep_ctrl_pkg::S_ASLEEP) &
             (sync_mode | mode == `MODE_NORMAL))
    begin
      next_synced    = 1'b1;                         // see RL11 RL17
      next_net_sleep = sync_rx_i.sleep;
      next_net_wake  = sync_rx_i.wake;
      next_sync_tx   = {1'b1, 1'b1, sync_rx_i.sleep, sync_rx_i.wake}; // see RL18
      if (sync_mode)
      begin
        next_state = sleep_ctrl_pkg::S_AWAKE;
        next_timer = sync_rx_i.wake;
      end
    end
    // joining nodes are answered by a synced mode 7 or 8 node whenever it listens
    else if (join_req_i & synced & sync_mode &
             (state != sleep_ctrl_pkg::S_ASLEEP))
      next_sync_tx = {1'b1, 1'b0, cur_sleep, cur_wake}; // see RL9
    // one poll per asynchronous wake
    if (wake_ev & poll_en & async_mode)
      next_poll = 1'b1;                              // see RL7
    lp_next    = next_state == sleep_ctrl_pkg::S_ASLEEP;
    next_awake = ~lp_next & (ind_en | mode == `MODE_CYCLIC |
                             mode == `MODE_CYCLIC_PIN); // see RL5 RL13
    next_cts_n = flow_en & lp_next;                  // see RL6 RL14
  end

  // sequencer flip-flops; the request passes two stages first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state     <= sleep_ctrl_pkg::S_AWAKE;
      timer     <= 16'h0000;
      presc     <= 32'h0000_0000;
      synced    <= 1'b0;
      net_sleep <= `SLEEP_PERIOD_RST;
      net_wake  <= `WAKE_TIME_RST;
      sync_tx   <= '0;
      req_s1    <= 1'b0;
      req_s2    <= 1'b0;
      poll      <= 1'b0;
      awake     <= 1'b0;
      cts_n     <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      timer     <= next_timer;
      presc     <= next_presc;
      synced    <= next_synced;
      net_sleep <= next_net_sleep;
      net_wake  <= next_net_wake;
      sync_tx   <= next_sync_tx;
      req_s1    <= sleep_request_in_i;               // see RL23
      req_s2    <= req_s1;
      poll      <= next_poll;
      awake     <= next_awake;
      cts_n     <= next_cts_n;
    end
  end

  // outputs; asleep means no radio or serial input is taken
  assign awake_o      = awake;
  assign cts_n_o      = cts_n;
  assign poll_o       = poll;
  assign sync_tx_o    = sync_tx;
  assign rx_ready_o   = state != sleep_ctrl_pkg::S_ASLEEP;  // see RL10
  // normal mode routes at any time; support waits for network wake
  assign data_tx_ok_o = (mode == `MODE_SUPPORT) ?
                        (state == sleep_ctrl_pkg::S_AWAKE) :
                        (state != sleep_ctrl_pkg::S_ASLEEP); // see RL9 RL17

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_pin_asleep;
    mode == `MODE_PIN && state == sleep_ctrl_pkg::S_ASLEEP;
  endsequence
  sequence s_sync_wake_start;
    sync_mode && state != sleep_ctrl_pkg::S_AWAKE && next_state ==
      sleep_ctrl_pkg::S_AWAKE && tdone && !local_chg;
  endsequence

  a_normal_awake: assert property (mode == `MODE_NORMAL |=> // see RL1
    state == sleep_ctrl_pkg::S_AWAKE && rx_ready_o)
    else $error("normal mode left awake state");
  a_pin_drain_wait: assert property (mode == `MODE_PIN && // see RL2
    state == sleep_ctrl_pkg::S_DRAIN && busy_i && req |=>
    state == sleep_ctrl_pkg::S_DRAIN)
    else $error("slept during traffic");
  a_pin_wake_up: assert property (s_pin_asleep ##0 !req |=> // see RL3
    state == sleep_ctrl_pkg::S_AWAKE)
    else $error("pin sleep did not end");
  a_ind_follows: assert property ((mode == `MODE_CYCLIC || // see RL5
    (mode == `MODE_SYNC && ind_en)) && $past(mode) == mode |->
    awake_o == (state != sleep_ctrl_pkg::S_ASLEEP))
    else $error("awake indicator wrong");
  a_cts_asleep: assert property (flow_en && $past(flow_en) && // see RL6
    state == sleep_ctrl_pkg::S_ASLEEP |-> cts_n_o)
    else $error("cts asserted while asleep");
  a_poll_once: assert property (poll_o |-> $past(wake_ev) ##1 // see RL7
    !poll_o)
    else $error("poll repeated");
  a_pin5_stay: assert property (mode == `MODE_CYCLIC_PIN && !req && // see RL8
    state == sleep_ctrl_pkg::S_AWAKE |=> state == sleep_ctrl_pkg::S_AWAKE)
    else $error("mode 5 slept with request low");
  a_support_on: assert property (mode == `MODE_SUPPORT [*2] |-> // see RL9
    state != sleep_ctrl_pkg::S_ASLEEP && rx_ready_o)
    else $error("support node slept");
  a_deaf_asleep: assert property (state == sleep_ctrl_pkg::S_ASLEEP |-> // see RL10
    !rx_ready_o && !data_tx_ok_o)
    else $error("input taken while asleep");
  a_timer_restart: assert property ((mode == `MODE_CYCLIC || // see RL16
    mode == `MODE_CYCLIC_PIN) && state == sleep_ctrl_pkg::S_AWAKE &&
    data |=> timer == $past(wake_time))
    else $error("inactivity timer not restarted");
  a_coord_sync: assert property (s_sync_wake_start ##0 coord |=> // see RL18
    sync_tx_o.valid && !sync_tx_o.relay ##1 !sync_tx_o.valid || sync_tx_o.relay)
    else $error("coordinator sync missing");
  a_noncoord_quiet: assert property (noncoord |-> !coord) // see RL20
    else $error("non-coordinator became coordinator");
  a_req_two_stage: assert property ($rose(sleep_request_in_i) ##1 // see RL23
    sleep_request_in_i |=> req_s2)
    else $error("request synchroniser broken");
endmodule
`default_nettype wire

// ==== verilog/sleep_ctrl_cfg.svh ====
// Purpose: addresses, field positions, resets and timing of the sleep ctrl
// Assumes: 32-bit classic Wishbone, byte addresses on adr_i[7:0]
// Notes:   times in registers count in ticks of TICK_TIME_NS
`ifndef SLEEP_CTRL_CFG_SVH
`define SLEEP_CTRL_CFG_SVH
// clock and tick timing
`define CLK_PERIOD_NS     40
`define TICK_TIME_NS      1000000
// register byte addresses
`define ADR_CTRL          8'h00
`define ADR_SLEEP_PERIOD  8'h04
`define ADR_WAKE_TIME     8'h08
`define ADR_STATUS        8'h0c
`define ADR_SYNCED_SLEEP  8'h10
`define ADR_SYNCED_WAKE   8'h14
// control fields
`define CTRL_MODE_LSB     0
`define CTRL_FLOW_BIT     4
`define CTRL_IND_BIT      5
`define CTRL_POLL_BIT     6
`define CTRL_PREF_BIT     8
`define CTRL_NONCOORD_BIT 9
`define CTRL_MASK         32'h0000_037f
// reset values
`define CTRL_RST          32'h0000_0000
`define SLEEP_PERIOD_RST  16'h0064
`define WAKE_TIME_RST     16'h0010
// sleep mode select encodings
`define MODE_NORMAL       4'h0
`define MODE_PIN          4'h1
`define MODE_CYCLIC       4'h4
`define MODE_CYCLIC_PIN   4'h5
`define MODE_SUPPORT      4'h7
`define MODE_SYNC         4'h8
`endif

// ==== verilog/sleep_ctrl_pkg.sv ====
// Purpose: shared types of the radio sleep mode controller
// Assumes: nothing is imported; users write sleep_ctrl_pkg::name
// Notes:   times are 16-bit tick counts
package sleep_ctrl_pkg;
  // a sleep or wake time in ticks
  typedef logic [15:0] stime_t;
  // sequencer states
  typedef enum logic [1:0] {S_AWAKE, S_DRAIN, S_ASLEEP, S_NET_SLEEP} seq_t;
  // sync message between peer nodes
  typedef struct packed {
    logic   valid;  // one-cycle pulse
    logic   relay;  // rebroadcast of another node's sync
    stime_t sleep;  // network sleep period
    stime_t wake;   // network wake time
  } sync_msg_t;
endpackage

// ==== bench/host_peer_model.sv ====
// Purpose: host pins and peer radio nodes facing the sleep controller
// Assumes: every change lands by non-blocking assignment at a rising edge
// Notes:   data arrival and sync are single-cycle or held levels
`timescale 1ns/1ps
`default_nettype none
module host_peer_model (
  // clock
  input  wire logic                   clk_i,
  // host side
  output logic                        req_o,
  output logic                        busy_o,
  output logic                        data_o,
  // peer side
  output sleep_ctrl_pkg::sync_msg_t   sync_o
);
  initial
  begin
    req_o  = 1'b0;
    busy_o = 1'b0;
    data_o = 1'b0;
    sync_o = '0;
  end
  //////////////////////////////////////////////////////////////////////////
  // host holds its request level until told otherwise
  task set_req(input logic v);
    @(posedge clk_i) req_o <= v;
  endtask
  // traffic in progress keeps the device from dropping into sleep
  task set_busy(input logic v);
    @(posedge clk_i) busy_o <= v;
  endtask
  // held data level: ignored while asleep, so it may start early
  task set_data(input logic v);
    @(posedge clk_i) data_o <= v;
  endtask
  // coordinator sync broadcast, valid for one cycle only
  task send_sync(input sleep_ctrl_pkg::stime_t s, input sleep_ctrl_pkg::stime_t w);
    @(posedge clk_i) sync_o <= '{1'b1, 1'b0, s, w};
    // stale times are inverted so they cannot pass for fresh ones
    @(posedge clk_i) sync_o <= '{1'b0, 1'b0, ~s, ~w};
  endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Purpose: self-checking bench of the radio sleep mode controller
// Assumes: tick shortened to 2 clocks; times below in ticks
// Notes:   bus master keeps classic single cycles, one idle between
`include "sleep_ctrl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_i = 1'b0;  // 25 MHz
  logic        rst_i = 1'b1;  // synchronous, active high
  logic        cyc, stb, we;  // bus request
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [31:0] dat, dat_o;
  logic        ack_o, req, busy, data, awake_o, cts_n_o;
  logic        rx_ready_o, tx_ok, poll_o;
  sleep_ctrl_pkg::sync_msg_t sync_rx, sync_tx;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cycles = 0;
  int          n_poll = 0;
  int          n_relay = 0;
  int          n_orig = 0;    // own sync messages sent
  logic        join_rq = 1'b0; // joining node asks for sync
  logic [3:0]  sel_w = 4'hf;  // byte lanes of the next bus cycle
  logic [31:0] q;
  initial {cyc, stb, we, sel, adr, dat} = '0;
  always #20 clk_i = ~clk_i;
  //////////////////////////////////////////////////////////////////////////
  radio_sleep_mode_controller #(.TICK_CYCLES(2)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .sel_i(sel), .adr_i(adr), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .sleep_request_in_i(req), .awake_o(awake_o), .cts_n_o(cts_n_o),
    .serial_rx_i(data), .rf_rx_i(data), .busy_i(busy),
    .rx_ready_o(rx_ready_o), .data_tx_ok_o(tx_ok), .poll_o(poll_o),
    .sync_rx_i(sync_rx), .join_req_i(join_rq), .sync_tx_o(sync_tx));
  host_peer_model far (.clk_i(clk_i), .req_o(req), .busy_o(busy),
    .data_o(data), .sync_o(sync_rx));
  //////////////////////////////////////////////////////////////////////////
  // monitors of one-cycle pulses and the hang limit
  always @(posedge clk_i)
  begin
    cycles++;
    if (poll_o === 1'b1) n_poll++;
    if (sync_tx.valid === 1'b1 && sync_tx.relay === 1'b1) n_relay++;
    if (sync_tx.valid === 1'b1 && sync_tx.relay === 1'b0) n_orig++;
    if (cycles >= 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle; waits for ack without assuming a latency
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, sel_w};
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    {cyc, stb, we} <= 3'b000;
    chk("ack", ack_o, 1'b1);
  endtask
  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task wait_ready(input logic v);
    int n;
    n = 0;
    while (rx_ready_o !== v && n < 400)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("ready level", rx_ready_o, v);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task t_reset();
    int n;
    n = 0;
    rdchk("ctrl", `ADR_CTRL, `CTRL_RST);
    rdchk("period", `ADR_SLEEP_PERIOD, {16'h0, `SLEEP_PERIOD_RST});
    rdchk("wake", `ADR_WAKE_TIME, {16'h0, `WAKE_TIME_RST});
    rdchk("unmapped", 8'h20, 32'h0);
    repeat (300) @(posedge clk_i) if (rx_ready_o !== 1'b1) n++;
    chk("mode0 awake", n, 0);
    n_relay = 0;
    far.send_sync(16'h0003, 16'h0005);
    repeat (2) @(posedge clk_i);
    chk("normal relay", n_relay, 1);
    $display("test reset done");
  endtask
  task t_pin();
    wb(1'b1, `ADR_CTRL, 32'h51);
    far.set_busy(1'b1);
    far.set_req(1'b1);
    repeat (8) @(posedge clk_i);
    chk("drain", rx_ready_o, 1'b1);
    far.set_busy(1'b0);
    wait_ready(1'b0);
    n_poll = 0;
    far.set_req(1'b0);
    wait_ready(1'b1);
    repeat (5) @(posedge clk_i);
    chk("poll count", n_poll, 1);
    $display("test pin sleep done");
  endtask
  task t_cyclic();
    int n;
    sel_w = 4'h1;
    wb(1'b1, `ADR_WAKE_TIME, 32'h0000_ab04); // only the low lane lands
    sel_w = 4'hf;
    wb(1'b1, `ADR_SLEEP_PERIOD, 32'h3);
    rdchk("wake rb", `ADR_WAKE_TIME, 32'h4);
    wb(1'b1, `ADR_CTRL, 32'h34);
    wait_ready(1'b0);
    chk("ind asleep", awake_o, 1'b0);
    chk("cts asleep", cts_n_o, 1'b1);
    far.set_data(1'b1);
    wait_ready(1'b1);
    chk("ind awake", awake_o, 1'b1);
    chk("cts awake", cts_n_o, 1'b0);
    repeat (3) @(posedge clk_i);
    far.set_data(1'b0);
    n = 0;
    while (rx_ready_o === 1'b1 && n < 100) @(posedge clk_i) n++;
    chk("extended", n >= 6 && n < 100, 1'b1);
    wait_ready(1'b1);
    n = 0;
    while (rx_ready_o === 1'b1 && n < 100) @(posedge clk_i) n++;
    chk("short wake", n <= 3, 1'b1);
    $display("test cyclic done");
  endtask
  task t_sync();
    wb(1'b1, `ADR_SLEEP_PERIOD, 32'h6);
    wb(1'b1, `ADR_CTRL, 32'h38);
    // start from a network wake so the sync meets a listening node
    wait_ready(1'b0);
    wait_ready(1'b1);
    n_relay = 0;
    far.send_sync(16'h0003, 16'h0005);
    repeat (3) @(posedge clk_i);
    chk("relay", n_relay, 1);
    n_orig = 0;
    @(posedge clk_i) join_rq <= 1'b1;
    @(posedge clk_i) join_rq <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("join answer", n_orig, 1);
    rdchk("used sleep", `ADR_SYNCED_SLEEP, 32'h3);
    rdchk("used wake", `ADR_SYNCED_WAKE, 32'h5);
    wait_ready(1'b0);
    chk("ind net sleep", awake_o, 1'b0);
    chk("cts net sleep", cts_n_o, 1'b1);
    $display("test sync done");
  endtask
  task t_modes();
    int n, lo, hi;
    n = 0;
    lo = 0;
    hi = 0;
    wb(1'b1, `ADR_CTRL, 32'h5);
    repeat (2) @(posedge clk_i);
    wait_ready(1'b1);
    repeat (40) @(posedge clk_i) if (rx_ready_o !== 1'b1) n++;
    chk("mode5 low req awake", n, 0);
    far.set_req(1'b1);
    wait_ready(1'b0);
    far.set_req(1'b0);
    wait_ready(1'b1);
    wb(1'b1, `ADR_CTRL, 32'h107);
    n_orig = 0;
    repeat (60) @(posedge clk_i)
    begin
      if (rx_ready_o !== 1'b1) n++;
      if (tx_ok === 1'b0) lo++;
      if (tx_ok === 1'b1) hi++;
    end
    chk("support awake", n, 0);
    chk("support tx gated", lo > 0 && hi > 0, 1'b1);
    chk("coord syncs", n_orig > 1, 1'b1);
    wb(1'b1, `ADR_CTRL, 32'h307);
    repeat (2) @(posedge clk_i);
    n_orig = 0;
    repeat (40) @(posedge clk_i);
    chk("noncoord quiet", n_orig, 0);
    $display("test modes done");
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_pin();
    t_cyclic();
    t_sync();
    t_modes();
    print_verdict();
  end
endmodule
`default_nettype wire
